// [core/shp_host_port.sv]
// How it works
// - normal bursts are cut to at most 16 words before strobes rise
// - strobes stay high at least 13 ns between bursts
// - direct fifo bursts are not cut and may run up to 31 words, one word per address step
// - fifo select is held with the address for the whole cycle
// - writes hold strobes 40 ns low, at least 30 ns high, and at least 70 ns apart
// - write data stands 7 ns before and through the strobe rise
`timescale 1ns/1ps
`default_nettype none

module shp_host_port
    import shp_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire shp_cmd_t          cmd,
    output logic                   rsp_valid,
    output shp_rsp_t               rsp,
    output shp_pins_t              pins,
    input  wire logic [DATA_W-1:0] data_in
);

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [2:0] {
        SHP_IDLE,
        SHP_RD,
        SHP_BURST,
        SHP_WR,
        SHP_GAP
    } shp_state_t;

    // sequencer state, timer, words left and registered outputs
    shp_state_t        state_q, state_d;
    logic [7:0]        tmr_q, tmr_d;
    logic [CNT_W-1:0]  left_q, left_d;
    shp_pins_t         pins_q, pins_d;
    shp_rsp_t          rsp_q, rsp_d;
    logic              rsp_v_q, rsp_v_d;
    logic [DATA_W-1:0] smp_q1, smp_q2, smp_q3;
    logic [DATA_W-1:0] smp_hold_q, smp_d;

    // pin levels with every strobe high and the bus let go
    localparam shp_pins_t PINS_IDLE = '{chip_select_n: 1'b1, read_strobe_n: 1'b1, write_strobe_n: 1'b1,
                                        fifo_sel: 1'b0, addr: '0, data_out: '0, data_oe: 1'b0};

    // ************************************************************
    // data bus sampling
    // ************************************************************
    // the device bus comes from outside this clock: three flops deep
    always_ff @(posedge ref_clk) begin
        smp_q1 <= data_in;
        smp_q2 <= smp_q1;
        smp_q3 <= smp_q2;
    end

    // a new bus value counts only once the last two stages agree;
    // a word caught mid-change keeps the last agreed value instead
    always_comb begin
        smp_d = smp_hold_q;
        if (smp_q2 == smp_q3) begin
            smp_d = smp_q3;
        end
    end

    // the agreed value, kept for the next mismatch
    always_ff @(posedge ref_clk) begin
        smp_hold_q <= smp_d;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // ready is combinational from the state; the rest are registers
    assign cmd_ready = (state_q == SHP_IDLE);
    assign rsp_valid = rsp_v_q;
    assign rsp       = rsp_q;
    assign pins      = pins_q;

    // ************************************************************
    // sequencer next state
    // ************************************************************
    always_comb begin
        state_d = state_q;
        tmr_d   = tmr_q;
        left_d  = left_q;
        pins_d  = pins_q;
        rsp_d   = rsp_q;
        rsp_v_d = 1'b0;
        unique case (state_q)
            // take a command: address, select and strobes go out together
            SHP_IDLE: begin
                if (cmd_valid) begin
                    pins_d.fifo_sel = cmd.fifo_sel;
                    pins_d.addr     = cmd.fifo_sel ?
                                      {{(ADDR_W-2){1'b0}}, cmd.addr[1:0]} : cmd.addr;
                    pins_d.chip_select_n = 1'b0;
                    unique case (cmd.op)
                        SHP_OP_WRITE: begin
                            pins_d.data_out       = cmd.wdata;
                            pins_d.data_oe        = 1'b1;
                            pins_d.write_strobe_n = 1'b0;
                            tmr_d   = 8'(WR_FULL_CYC);
                            state_d = SHP_WR;
                        end
                        SHP_OP_BURST: begin
                            pins_d.data_oe       = 1'b0;
                            pins_d.read_strobe_n = 1'b0;
                            // length 0 means one word; plain bursts stop at the limit
                            if (cmd.len == CNT_ZERO)
                                left_d = CNT_ONE;
                            else if (!cmd.fifo_sel && cmd.len > BURST_MAX)
                                left_d = BURST_MAX;
                            else
                                left_d = cmd.len;
                            tmr_d   = 8'(BW_CYC + 2);
                            state_d = SHP_BURST;
                        end
                        default: begin
                            pins_d.data_oe       = 1'b0;
                            pins_d.read_strobe_n = 1'b0;
                            tmr_d   = 8'(RD_FULL_CYC + 2);
                            state_d = SHP_RD;
                        end
                    endcase
                end
            end
            SHP_RD: begin
                // two extra cycles cover the input sampling flops
                if (tmr_q == 8'h01) begin
                    rsp_d.rdata          = smp_d;
                    rsp_d.last           = 1'b1;
                    rsp_v_d              = 1'b1;
                    pins_d.chip_select_n = 1'b1;
                    pins_d.read_strobe_n = 1'b1;
                    tmr_d   = 8'(CSH_CYC);
                    state_d = SHP_GAP;
                end else begin
                    tmr_d = tmr_q - 8'h01;
                end
            end
            // one word per address step, strobes held low between words
            SHP_BURST: begin
                if (tmr_q == 8'h01) begin
                    rsp_d.rdata = smp_d;
                    rsp_v_d     = 1'b1;
                    if (left_q == CNT_ONE) begin
                        rsp_d.last           = 1'b1;
                        pins_d.chip_select_n = 1'b1;
                        pins_d.read_strobe_n = 1'b1;
                        tmr_d   = 8'(CSH_CYC);
                        state_d = SHP_GAP;
                    end else begin
                        // next word: step the low address bits, strobes stay low
                        rsp_d.last  = 1'b0;
                        pins_d.addr = {pins_q.addr[ADDR_W-1:2], pins_q.addr[1:0] + 2'h1};
                        left_d      = left_q - CNT_ONE;
                        tmr_d       = 8'(BW_CYC + 2);
                    end
                end else begin
                    tmr_d = tmr_q - 8'h01;
                end
            end
            // write strobe low for the least low time, then rises
            SHP_WR: begin
                if (tmr_q == 8'h01) begin
                    // data keeps standing through the rising edge
                    pins_d.chip_select_n  = 1'b1;
                    pins_d.write_strobe_n = 1'b1;
                    tmr_d   = 8'(CSH_CYC);
                    state_d = SHP_GAP;
                end else begin
                    tmr_d = tmr_q - 8'h01;
                end
            end
            // strobes high for the least high time before the next command
            SHP_GAP: begin
                pins_d.data_oe = 1'b0;
                if (tmr_q == 8'h01) begin
                    state_d = SHP_IDLE;
                end else begin
                    tmr_d = tmr_q - 8'h01;
                end
            end
            default: state_d = SHP_IDLE;
        endcase
    end

    // ************************************************************
    // sequencer registers
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= SHP_IDLE;
            tmr_q   <= 8'h00;
            left_q  <= CNT_ZERO;
            pins_q  <= PINS_IDLE;
            rsp_q   <= '0;
            rsp_v_q <= 1'b0;
        end else begin
            state_q <= state_d;
            tmr_q   <= tmr_d;
            left_q  <= left_d;
            pins_q  <= pins_d;
            rsp_q   <= rsp_d;
            rsp_v_q <= rsp_v_d;
        end
    end

endmodule

`default_nettype wire

// [core/shp_pkg.sv]
package shp_pkg;

    // ************************************************************
    // bus widths
    // ************************************************************
    localparam int unsigned DATA_W  = 16;
    localparam int unsigned ADDR_W  = 7;    // address bits 7:1
    localparam int unsigned CNT_W   = 5;

    // ************************************************************
    // timing figures in ns and derived cycle counts
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned T_CSL_NS      = 32;  // strobe low, least
    localparam int unsigned T_CSH_NS      = 13;  // strobe high between cycles, least
    localparam int unsigned T_CYCLE_NS    = 45;  // cycle / address cycle, least
    localparam int unsigned T_CSDV_NS     = 30;  // strobe to data valid, most
    localparam int unsigned T_ADV_NS      = 40;  // address stable to data valid, most
    localparam int unsigned T_DSU_NS      = 7;   // data setup before strobe rise, least

    // least times round up
    localparam int unsigned CSL_CYC  = (T_CSL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CSH_CYC  = (T_CSH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_CYC  = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DSU_CYC  = (T_DSU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // sample points wait the device's longest figure, rounded up
    localparam int unsigned CSDV_CYC = (T_CSDV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ADV_CYC  = (T_ADV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // low time of a read word: data must be sampled after csdv and csl
    localparam int unsigned RD_LOW_CYC  = (CSDV_CYC + 1 > CSL_CYC) ? CSDV_CYC + 1 : CSL_CYC;
    localparam int unsigned RD_FULL_CYC = (RD_LOW_CYC + CSH_CYC > CYC_CYC) ? RD_LOW_CYC : CYC_CYC - CSH_CYC;
    // address phase of a burst word: address cycle and adv
    localparam int unsigned BW_CYC      = (ADV_CYC + 1 > CYC_CYC) ? ADV_CYC + 1 : CYC_CYC;
    localparam int unsigned WR_LOW_CYC  = (CSL_CYC > DSU_CYC) ? CSL_CYC : DSU_CYC;
    localparam int unsigned WR_FULL_CYC = (WR_LOW_CYC + CSH_CYC > CYC_CYC) ? WR_LOW_CYC : CYC_CYC - CSH_CYC;

    localparam logic [CNT_W-1:0] BURST_MAX = 5'h10;  // words per normal burst
    localparam logic [CNT_W-1:0] CNT_ONE   = 5'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 5'h00;

    // ************************************************************
    // host command and answer
    // ************************************************************
    typedef enum logic [1:0] {
        SHP_OP_READ,
        SHP_OP_WRITE,
        SHP_OP_BURST
    } shp_op_t;

    typedef struct packed {
        shp_op_t             op;
        logic                fifo_sel;   // direct fifo mode
        logic [ADDR_W-1:0]   addr;       // word address of the first access
        logic [DATA_W-1:0]   wdata;
        logic [CNT_W-1:0]    len;        // burst words, 0 counts as 1
    } shp_cmd_t;

    typedef struct packed {
        logic [DATA_W-1:0]   rdata;
        logic                last;
    } shp_rsp_t;

    // ************************************************************
    // pins towards the device
    // ************************************************************
    typedef struct packed {
        logic                chip_select_n;
        logic                read_strobe_n;
        logic                write_strobe_n;
        logic                fifo_sel;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data_out;
        logic                data_oe;
    } shp_pins_t;

endpackage

// [tb/shp_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none

module shp_dev_model
    import shp_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire shp_pins_t         pins,
    output logic [DATA_W-1:0]      data_in
);
    logic              rd_act, wr_act, prv_rd, prv_wr, prv_sel;
    logic [ADDR_W-1:0] prv_addr;
    logic [15:0]       pop_q, wr_q, tx_q, p;
    logic              wsel_q;

    assign rd_act = !pins.chip_select_n && !pins.read_strobe_n;
    assign wr_act = !pins.chip_select_n && !pins.write_strobe_n;

    initial begin
        {data_in, pop_q, wr_q, tx_q, wsel_q} = '0;
        {prv_rd, prv_wr, prv_sel, prv_addr} = '0;
    end

    // device side: register reads, receive pops, write capture
    always @(posedge ref_clk) begin
        p = pop_q;
        if (prv_rd && prv_sel && (!rd_act || pins.addr != prv_addr))
            p = p + 16'h0001;                  // one pop per word
        pop_q <= p;
        if (rd_act)
            data_in <= pins.fifo_sel ? 16'hc000 + p : {9'h000, pins.addr};
        else
            data_in <= ~data_in;               // released bus, never stale
        if (prv_wr && !wr_act) begin           // capture at ending edge
            wr_q   <= pins.data_out;
            wsel_q <= prv_sel;
            if (prv_sel)
                tx_q <= tx_q + 16'h0001;       // transmit push
        end
        prv_rd   <= rd_act;
        prv_wr   <= wr_act;
        prv_sel  <= pins.fifo_sel;
        prv_addr <= pins.addr;
    end
endmodule

`default_nettype wire

// [tb/shp_host_port_chk.sv]
`timescale 1ns/1ps
`default_nettype none

module shp_host_port_chk
    import shp_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              cmd_valid,
    input  wire logic              cmd_ready,
    input  wire shp_cmd_t          cmd,
    input  wire logic              rsp_valid,
    input  wire shp_rsp_t          rsp,
    input  wire shp_pins_t         pins,
    input  wire logic [DATA_W-1:0] data_in
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             fs_q, fs_d;
    logic             take;

    // word count of the command in flight
    assign take = cmd_valid && cmd_ready;
    always_comb begin
        cnt_d = take ? CNT_ZERO : cnt_q + {4'h0, rsp_valid};
        fs_d  = take ? cmd.fifo_sel : fs_q;
    end
    always_ff @(posedge ref_clk) begin
        cnt_q <= rst ? CNT_ZERO : cnt_d;
        fs_q  <= rst ? 1'b0 : fs_d;
    end

    chk_burst_max: assert property (rsp_valid && !fs_q |-> cnt_q < BURST_MAX)
        else $error("normal burst longer than limit");
    chk_strobe_high: assert property ($rose(pins.chip_select_n) |=> pins.chip_select_n)
        else $error("select high too briefly");
    chk_rsp_in_read: assert property (rsp_valid |-> $past(!pins.chip_select_n && !pins.read_strobe_n))
        else $error("word answered outside a read");
    chk_read_answer: assert property (take && cmd.op == SHP_OP_READ |-> ##7 rsp_valid && rsp.last)
        else $error("single read answer late or missing");
    chk_direct_addr: assert property (!pins.chip_select_n && pins.fifo_sel |-> pins.addr[6:2] == 5'h00)
        else $error("upper address driven in direct mode");
    chk_sel_stable: assert property (!pins.chip_select_n && $past(!pins.chip_select_n) |-> $stable(pins.fifo_sel))
        else $error("fifo select moved in a cycle");
    chk_one_strobe: assert property (!(!pins.read_strobe_n && !pins.write_strobe_n))
        else $error("read and write strobes both low");
    chk_write_low: assert property ($fell(pins.write_strobe_n) |-> !pins.write_strobe_n [*4])
        else $error("write strobe low too briefly");
    chk_wr_data: assert property ($rose(pins.write_strobe_n) |-> pins.data_oe && $stable(pins.data_out))
        else $error("write data not held at strobe rise");
    chk_no_oe_read: assert property (!pins.read_strobe_n |-> !pins.data_oe)
        else $error("host drives bus during read");

    cov_read: cover property (take && cmd.op == SHP_OP_READ);
    cov_write: cover property (take && cmd.op == SHP_OP_WRITE && cmd.fifo_sel);
    cov_full_burst: cover property (rsp_valid && rsp.last && cnt_q == 5'h0f);
endmodule

bind shp_host_port shp_host_port_chk chk (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .data_in(data_in));

`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import shp_pkg::*;

    logic ref_clk, rst, cmd_valid, cmd_ready, rsp_valid;
    shp_cmd_t cmd;
    shp_rsp_t rsp;
    shp_pins_t pins;
    logic [DATA_W-1:0] data_in;
    int n_mismatch, checked;
    logic [15:0] rx;

    shp_host_port DUT (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
        .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .data_in(data_in));
    shp_dev_model dev (.ref_clk(ref_clk), .pins(pins), .data_in(data_in));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task results;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // hand one command over at a falling edge
    task issue(input shp_op_t op, input logic fs, input logic [6:0] ad, input logic [15:0] wd, input logic [4:0] ln);
        int i;
        for (i = 0; i < 200 && cmd_ready !== 1'b1; i++) @(negedge ref_clk);
        if (i == 200) begin n_mismatch++; results(); end
        cmd_valid = 1'b1;
        cmd = '{op: op, fifo_sel: fs, addr: ad, wdata: wd, len: ln};
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        check({15'h0, cmd_ready}, 16'h0000);
    endtask

    // collect one answered word and compare it
    task word(input logic [15:0] exp, input logic lst);
        int i;
        for (i = 0; i < 40 && rsp_valid !== 1'b1; i++) @(negedge ref_clk);
        if (i == 40) begin n_mismatch++; results(); end
        check(rsp.rdata, exp);
        check({15'h0, rsp.last}, {15'h0, lst});
        @(negedge ref_clk);
        check({15'h0, rsp_valid}, 16'h0000);
    endtask

    task t_single;
        issue(SHP_OP_READ, 1'b0, 7'h2d, 16'h0, 5'h0);
        word(16'h002d, 1'b1);
        issue(SHP_OP_READ, 1'b1, 7'h7e, 16'h0, 5'h0);
        word(16'hc000 + rx, 1'b1);
        rx++;
        $display("single reads done");
    endtask

    task t_burst;
        issue(SHP_OP_BURST, 1'b0, 7'h31, 16'h0, 5'h00);
        word(16'h0031, 1'b1);
        issue(SHP_OP_BURST, 1'b0, 7'h31, 16'h0, 5'h1f);
        for (int k = 0; k < 16; k++) word({9'h0, 5'h0c, 2'(k + 1)}, k == 15);
        issue(SHP_OP_BURST, 1'b1, 7'h55, 16'h0, 5'h14);
        for (int k = 0; k < 20; k++) word(16'hc000 + rx + 16'(k), k == 19);
        rx += 16'd20;
        $display("bursts done");
    endtask

    task t_write;
        issue(SHP_OP_WRITE, 1'b0, 7'h05, 16'h1234, 5'h0);
        issue(SHP_OP_WRITE, 1'b1, 7'h7f, 16'hbeef, 5'h0);
        issue(SHP_OP_READ, 1'b0, 7'h01, 16'h0, 5'h0);
        word(16'h0001, 1'b1);
        check(dev.wr_q, 16'hbeef);
        check(dev.tx_q, 16'h0001);
        check({15'h0, dev.wsel_q}, 16'h0001);
        $display("writes done");
    endtask

    initial begin
        {n_mismatch, checked} = '0;
        rx = 16'h0000;
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd = '0;
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        t_single();
        t_burst();
        t_write();
        results();
    end
endmodule

`default_nettype wire
